// >>> common/dppio_consts.svh
`ifndef DPPIO_CONSTS_SVH
`define DPPIO_CONSTS_SVH

// register indices as printed; byte address is four times the index
`define DPPIO_IDX_B_LATCH     8'h01
`define DPPIO_IDX_D_LATCH     8'h03
`define DPPIO_IDX_B_DIR       8'h04
`define DPPIO_IDX_D_DIR       8'h05
`define DPPIO_IDX_ADC_SEL     8'h06
`define DPPIO_ADDR_W          12
`define DPPIO_PORT_W          8
`define DPPIO_SEL_W           5
`define DPPIO_DIR_RESET       8'h00
`define DPPIO_SEL_RESET       5'h1f
`define DPPIO_RESP_OKAY       2'b00
`define DPPIO_RESP_SLVERR     2'b10

`endif

// >>> common/dppio_pkg.sv
package dppio_pkg;
    // one 8-bit port at the pins
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe_n;
    } dppio_pins_t;

    typedef enum logic [2:0] {
        DPPIO_REG_B_LATCH,
        DPPIO_REG_D_LATCH,
        DPPIO_REG_B_DIR,
        DPPIO_REG_D_DIR,
        DPPIO_REG_ADC_SEL,
        DPPIO_REG_NONE
    } dppio_reg_t;
endpackage

// >>> hdl/dppio_port.sv
`timescale 1ns/100ps
`include "dppio_consts.svh"

// one 8-bit port: latch, direction, synchronised pin sample, read mux
module dppio_port (
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    input  wire logic                      latch_we,
    input  wire logic                      dir_we,
    input  wire logic [7:0]                wdata,
    input  wire logic [7:0]                wstrb_mask,
    input  wire logic [7:0]                pin_in,
    input  wire logic [7:0]                adc_claim,
    output dppio_pkg::dppio_pins_t         pins,
    output logic      [7:0]                latch_q,
    output logic      [7:0]                dir_q,
    output logic      [7:0]                data_rd
);
    import dppio_pkg::*;

    logic [7:0] meta_ff;
    logic [7:0] sync_ff;
    logic [7:0] latch_ff;
    logic [7:0] dir_ff;
    logic [7:0] out_ff;
    logic [7:0] oe_n_ff;
    wire  [7:0] nxt_latch = (latch_ff & ~wstrb_mask) | (wdata & wstrb_mask);
    wire  [7:0] nxt_dir   = (dir_ff & ~wstrb_mask) | (wdata & wstrb_mask);

    // latch has no reset: it keeps its value through any reset
    always_ff @(posedge aclk) begin
        if (latch_we) begin
            latch_ff <= nxt_latch;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dir_ff <= `DPPIO_DIR_RESET;
        end else if (dir_we) begin
            dir_ff <= nxt_dir;
        end
    end

    always_ff @(posedge aclk) begin
        meta_ff <= pin_in;
        sync_ff <= meta_ff;
    end

    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_pin
            // converter claim beats direction and latch
            wire drive = dir_ff[i] & ~adc_claim[i];
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    oe_n_ff[i] <= 1'b1;
                    out_ff[i]  <= 1'b0;
                end else begin
                    oe_n_ff[i] <= ~drive;
                    out_ff[i]  <= latch_ff[i];
                end
            end
        end
    endgenerate

    assign pins.out  = out_ff;
    assign pins.oe_n = oe_n_ff;
    assign latch_q   = latch_ff;
    assign dir_q     = dir_ff;
    assign data_rd   = (dir_ff & latch_ff) | (~dir_ff & sync_ff);
endmodule

// >>> hdl/dppio_top.sv
`timescale 1ns/100ps
`include "dppio_consts.svh"

module dppio_top (
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    input  wire logic [`DPPIO_ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [`DPPIO_ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    input  wire logic [7:0]                portb_pin_in,
    output dppio_pkg::dppio_pins_t         portb_pins,
    input  wire logic [7:0]                portd_pin_in,
    output dppio_pkg::dppio_pins_t         portd_pins,
    output logic [`DPPIO_SEL_W-1:0]        analog_channel_select
);
    import dppio_pkg::*;

    function automatic dppio_reg_t decode(input logic [`DPPIO_ADDR_W-1:0] a);
        dppio_reg_t r;
        r = DPPIO_REG_NONE;
        if (a[1:0] != 2'b00) begin
            r = DPPIO_REG_NONE;
        end else if (a[`DPPIO_ADDR_W-1:2] == 10'(`DPPIO_IDX_B_LATCH)) begin
            r = DPPIO_REG_B_LATCH;
        end else if (a[`DPPIO_ADDR_W-1:2] == 10'(`DPPIO_IDX_D_LATCH)) begin
            r = DPPIO_REG_D_LATCH;
        end else if (a[`DPPIO_ADDR_W-1:2] == 10'(`DPPIO_IDX_B_DIR)) begin
            r = DPPIO_REG_B_DIR;
        end else if (a[`DPPIO_ADDR_W-1:2] == 10'(`DPPIO_IDX_D_DIR)) begin
            r = DPPIO_REG_D_DIR;
        end else if (a[`DPPIO_ADDR_W-1:2] == 10'(`DPPIO_IDX_ADC_SEL)) begin
            r = DPPIO_REG_ADC_SEL;
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // write channel: address and data latched separately, either order
    logic                      aw_held_ff;
    logic                      w_held_ff;
    logic                      awready_ff;
    logic                      wready_ff;
    logic [`DPPIO_ADDR_W-1:0]  awaddr_ff;
    logic [31:0]               wdata_ff;
    logic [3:0]                wstrb_ff;
    logic                      bvalid_ff;
    logic [1:0]                bresp_ff;
    logic [`DPPIO_SEL_W-1:0]   sel_ff;

    wire                       aw_take  = s_axi_awvalid & awready_ff;
    wire                       w_take   = s_axi_wvalid & wready_ff;
    wire                       wr_fire  = aw_held_ff & w_held_ff;
    wire                       b_done   = bvalid_ff & s_axi_bready;
    wire dppio_reg_t           wr_reg   = decode(awaddr_ff);
    wire                       wr_lane0 = wr_fire & wstrb_ff[0];
    wire [7:0]                 wr_mask  = 8'hff;

    // one strobe per register that software can change
    wire                       wr_b_latch = wr_lane0 && wr_reg == DPPIO_REG_B_LATCH;
    wire                       wr_d_latch = wr_lane0 && wr_reg == DPPIO_REG_D_LATCH;
    wire                       wr_b_dir   = wr_lane0 && wr_reg == DPPIO_REG_B_DIR;
    wire                       wr_d_dir   = wr_lane0 && wr_reg == DPPIO_REG_D_DIR;
    wire                       wr_sel     = wr_lane0 && wr_reg == DPPIO_REG_ADC_SEL;

    ////////////////////////////////////////////////////////////////////////
    // next state of the write handshake
    wire                       nxt_aw_held = ~wr_fire & (aw_take | aw_held_ff);
    wire                       nxt_w_held  = ~wr_fire & (w_take | w_held_ff);
    // set wins, though a take never meets a pending response
    wire                       nxt_bvalid  = wr_fire | (bvalid_ff & ~b_done);
    // readies registered so every bus output leaves a flip-flop
    wire                       nxt_awready = ~nxt_aw_held & ~nxt_bvalid;
    wire                       nxt_wready  = ~nxt_w_held & ~nxt_bvalid;
    wire [`DPPIO_ADDR_W-1:0]   nxt_awaddr  = aw_take ? s_axi_awaddr : awaddr_ff;
    wire [31:0]                nxt_wdata   = w_take ? s_axi_wdata : wdata_ff;
    wire [3:0]                 nxt_wstrb   = w_take ? s_axi_wstrb : wstrb_ff;
    wire [1:0]                 wr_resp     = (wr_reg == DPPIO_REG_NONE) ? `DPPIO_RESP_SLVERR
                                                                      : `DPPIO_RESP_OKAY;
    wire [1:0]                 nxt_bresp   = wr_fire ? wr_resp : bresp_ff;
    // all-ones parks the converter off every port B pin
    wire [`DPPIO_SEL_W-1:0]    nxt_sel     = wr_sel ? wdata_ff[`DPPIO_SEL_W-1:0] : sel_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            awready_ff <= 1'b1;
            wready_ff  <= 1'b1;
        end else begin
            aw_held_ff <= nxt_aw_held;
            w_held_ff  <= nxt_w_held;
            bvalid_ff  <= nxt_bvalid;
            awready_ff <= nxt_awready;
            wready_ff  <= nxt_wready;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awaddr_ff <= '0;
            wdata_ff  <= '0;
            wstrb_ff  <= '0;
            bresp_ff  <= `DPPIO_RESP_OKAY;
        end else begin
            awaddr_ff <= nxt_awaddr;
            wdata_ff  <= nxt_wdata;
            wstrb_ff  <= nxt_wstrb;
            bresp_ff  <= nxt_bresp;
        end
    end

    assign s_axi_awready = awready_ff;
    assign s_axi_wready  = wready_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_ff <= `DPPIO_SEL_RESET;
        end else begin
            sel_ff <= nxt_sel;
        end
    end
    assign analog_channel_select = sel_ff;

    ////////////////////////////////////////////////////////////////////////
    // ports
    wire [7:0] adc_claim_b;
    genvar k;
    generate
        for (k = 0; k < 8; k = k + 1) begin : g_claim
            assign adc_claim_b[k] = (sel_ff == 5'(k));
        end
    endgenerate

    logic [7:0] b_rd;
    logic [7:0] d_rd;
    logic [7:0] b_dir;
    logic [7:0] d_dir;

    dppio_port u_portb (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .latch_we   (wr_b_latch),
        .dir_we     (wr_b_dir),
        .wdata      (wdata_ff[7:0]),
        .wstrb_mask (wr_mask),
        .pin_in     (portb_pin_in),
        .adc_claim  (adc_claim_b),
        .pins       (portb_pins),
        .latch_q    (),
        .dir_q      (b_dir),
        .data_rd    (b_rd)
    );

    dppio_port u_portd (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .latch_we   (wr_d_latch),
        .dir_we     (wr_d_dir),
        .wdata      (wdata_ff[7:0]),
        .wstrb_mask (wr_mask),
        .pin_in     (portd_pin_in),
        .adc_claim  (8'h00),
        .pins       (portd_pins),
        .latch_q    (),
        .dir_q      (d_dir),
        .data_rd    (d_rd)
    );

    ////////////////////////////////////////////////////////////////////////
    // read channel: one cycle from address to data
    logic                      arready_ff;
    logic                      rvalid_ff;
    logic [31:0]               rdata_ff;
    logic [1:0]                rresp_ff;
    wire                       ar_take = s_axi_arvalid & arready_ff;
    wire                       r_done  = rvalid_ff & s_axi_rready;
    wire dppio_reg_t           rd_reg  = decode(s_axi_araddr);
    wire [7:0]                 rd_byte =
        (rd_reg == DPPIO_REG_B_LATCH) ? b_rd :
        (rd_reg == DPPIO_REG_D_LATCH) ? d_rd :
        (rd_reg == DPPIO_REG_B_DIR)   ? b_dir :
        (rd_reg == DPPIO_REG_D_DIR)   ? d_dir :
        (rd_reg == DPPIO_REG_ADC_SEL) ? {3'h0, sel_ff} : 8'h00;
    wire [1:0]                 rd_resp = (rd_reg == DPPIO_REG_NONE) ? `DPPIO_RESP_SLVERR
                                                                    : `DPPIO_RESP_OKAY;
    wire                       nxt_rvalid  = ar_take | (rvalid_ff & ~r_done);
    wire                       nxt_arready = ~nxt_rvalid;
    wire [31:0]                nxt_rdata   = ar_take ? {24'h000000, rd_byte} : rdata_ff;
    wire [1:0]                 nxt_rresp   = ar_take ? rd_resp : rresp_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= '0;
            rresp_ff   <= `DPPIO_RESP_OKAY;
        end else begin
            arready_ff <= nxt_arready;
            rvalid_ff  <= nxt_rvalid;
            rdata_ff   <= nxt_rdata;
            rresp_ff   <= nxt_rresp;
        end
    end

    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;
endmodule

// >>> dv/dppio_monitor.sv
`timescale 1ns/100ps

// watches bus reads and both pin ports of the top module
module dppio_monitor (
    input wire logic              aclk,
    input wire logic              aresetn,
    input wire logic [11:0]       s_axi_araddr,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_bvalid,
    input wire logic [7:0]        portb_pin_in,
    input dppio_pkg::dppio_pins_t portb_pins,
    input wire logic [7:0]        portd_pin_in,
    input dppio_pkg::dppio_pins_t portd_pins,
    input wire logic [4:0]        analog_channel_select
);
    import dppio_pkg::*;
    logic [11:0] rd_addr_ff;
    logic [11:0] nxt_rd_addr;
    // remember which register the pending read data belongs to
    assign nxt_rd_addr = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : rd_addr_ff;
    always_ff @(posedge aclk) begin
        rd_addr_ff <= nxt_rd_addr;
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking mon_cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_b_reset_float: assert property ($rose(aresetn) |-> portb_pins.oe_n == 8'hff)
        else $error("port b drives after reset");
    a_d_reset_float: assert property ($rose(aresetn) |-> portd_pins.oe_n == 8'hff)
        else $error("port d drives after reset");
    a_claim_floats: assert property (analog_channel_select < 5'h08 &&
        $stable(analog_channel_select) |-> portb_pins.oe_n[analog_channel_select[2:0]])
        else $error("claimed port b pin still driven");
    a_b_oe_cause: assert property (!$stable(portb_pins.oe_n) |-> $past(s_axi_bvalid))
        else $error("port b enable moved without a write");
    a_d_oe_cause: assert property (!$stable(portd_pins.oe_n) |-> $past(s_axi_bvalid))
        else $error("port d enable moved without a write");
    a_d_read_latch: assert property ($rose(s_axi_rvalid) && rd_addr_ff == 12'h00c |->
        ((s_axi_rdata[7:0] ^ portd_pins.out) & ~portd_pins.oe_n) == 8'h00)
        else $error("port d output bit read wrong");
    a_d_read_pin: assert property ($rose(s_axi_rvalid) && rd_addr_ff == 12'h00c |->
        ((s_axi_rdata[7:0] ^ portd_pin_in) & portd_pins.oe_n) == 8'h00)
        else $error("port d input bit read wrong");
    a_b_read_mix: assert property ($rose(s_axi_rvalid) && rd_addr_ff == 12'h004 |->
        s_axi_rdata[7:0] == ((portb_pins.out & ~portb_pins.oe_n) |
        (portb_pin_in & portb_pins.oe_n))) else $error("port b read wrong");
endmodule

// >>> dv/dppio_board.sv
`timescale 1ns/100ps

// board side of one port: a floated pin follows the outside source
module dppio_board (
    input dppio_pkg::dppio_pins_t pins,
    input wire logic [7:0]        ext_level,
    output logic     [7:0]        pin_in
);
    import dppio_pkg::*;
    // no keeper: a released pin never shows the old drive
    assign pin_in = (pins.out & ~pins.oe_n) | (ext_level & pins.oe_n);
endmodule

// >>> dv/testbench.sv
`timescale 1ns/100ps
`include "dppio_consts.svh"

module testbench;
    import dppio_pkg::*;
    localparam logic [7:0] EXT_B = 8'h96;
    localparam logic [7:0] EXT_D = 8'h3c;
    logic              aclk = 1'b0;
    logic              aresetn = 1'b0;
    logic [11:0]       s_axi_awaddr = 12'h000;
    logic [11:0]       s_axi_araddr = 12'h000;
    logic [31:0]       s_axi_wdata = 32'h00000000;
    logic [3:0]        s_axi_wstrb = 4'hf;
    logic              s_axi_awvalid = 1'b0;
    logic              s_axi_wvalid = 1'b0;
    logic              s_axi_bready = 1'b0;
    logic              s_axi_arvalid = 1'b0;
    logic              s_axi_rready = 1'b0;
    logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]        s_axi_bresp, s_axi_rresp, resp_q, bresp_q;
    logic [31:0]       s_axi_rdata, rd_q;
    logic [7:0]        portb_pin_in, portd_pin_in;
    dppio_pins_t       portb_pins, portd_pins;
    logic [4:0]        analog_channel_select;
    int                mismatches = 0;
    int                checks = 0;
    int                cycles = 0;

    always #20 aclk = ~aclk;

    dppio_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .portb_pin_in,
        .portb_pins, .portd_pin_in, .portd_pins, .analog_channel_select);
    dppio_board brd_b_u (.pins(portb_pins), .ext_level(EXT_B), .pin_in(portb_pin_in));
    dppio_board brd_d_u (.pins(portd_pins), .ext_level(EXT_D), .pin_in(portd_pin_in));

    ////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        if (mismatches == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic do_reset();
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
    endtask

    // handshake judged at the falling edge, since inputs move only at rising ones
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic aw_t, w_t, b_t;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge aclk);
            aw_t = s_axi_awready & s_axi_awvalid;
            w_t = s_axi_wready & s_axi_wvalid;
            b_t = s_axi_bvalid;
            bresp_q = s_axi_bresp;
            @(posedge aclk);
            if (aw_t) s_axi_awvalid <= 1'b0;
            if (w_t) s_axi_wvalid <= 1'b0;
        end while (!b_t);
        s_axi_bready <= 1'b0;
        repeat (4) @(negedge aclk);
    endtask

    task automatic rd(input logic [11:0] a);
        logic ar_t, r_t;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge aclk);
            ar_t = s_axi_arready & s_axi_arvalid;
            r_t = s_axi_rvalid;
            rd_q = s_axi_rdata;
            resp_q = s_axi_rresp;
            @(posedge aclk);
            if (ar_t) s_axi_arvalid <= 1'b0;
        end while (!r_t);
        s_axi_rready <= 1'b0;
    endtask

    task automatic rchk(input string what, input logic [11:0] a, input logic [7:0] exp);
        rd(a);
        chk(what, exp, rd_q[7:0]);
        chk("rresp", {6'h00, `DPPIO_RESP_OKAY}, {6'h00, resp_q});
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_state();
        @(negedge aclk);
        chk("b oe_n", 8'hff, portb_pins.oe_n);
        chk("d oe_n", 8'hff, portd_pins.oe_n);
        rchk("b dir", 12'h010, 8'h00);
        rchk("d dir", 12'h014, 8'h00);
        chk("sel", 8'h1f, {3'h0, analog_channel_select});
        rchk("sel rd", 12'h018, 8'h1f);
    endtask

    task automatic t_portd();
        wr(12'h00c, 8'ha5);
        chk("bresp", {6'h00, `DPPIO_RESP_OKAY}, {6'h00, bresp_q});
        chk("d oe_n", 8'hff, portd_pins.oe_n);
        rchk("d in", 12'h00c, EXT_D);
        wr(12'h014, 8'h0f);
        chk("d oe_n", 8'hf0, portd_pins.oe_n);
        chk("d out", 8'h05, portd_pins.out & 8'h0f);
        rchk("d mix", 12'h00c, 8'h35);
        rchk("d dir", 12'h014, 8'h0f);
        wr(12'h00c, 8'h5a);
        rchk("d mix2", 12'h00c, 8'h3a);
    endtask

    task automatic t_portb();
        wr(12'h004, 8'h3c);
        wr(12'h010, 8'hff);
        wr(12'h018, 8'h02);
        chk("sel", 8'h02, {3'h0, analog_channel_select});
        chk("b oe_n", 8'h04, portb_pins.oe_n);
        chk("b out", 8'h38, portb_pins.out & 8'hfb);
        wr(12'h018, 8'h1f);
        chk("b oe_n", 8'h00, portb_pins.oe_n);
        rchk("b rd", 12'h004, 8'h3c);
        wr(12'h010, 8'h0f);
        rchk("b mix", 12'h004, 8'h9c);
    endtask

    // unmapped or misaligned place: refused, write leaves the port alone
    // a write without lane 0 is accepted but changes nothing
    task automatic t_unmapped();
        rd(12'h020);
        chk("bad rresp", {6'h00, `DPPIO_RESP_SLVERR}, {6'h00, resp_q});
        chk("bad rdata", 8'h00, rd_q[7:0]);
        rd(12'h00e);
        chk("odd rresp", {6'h00, `DPPIO_RESP_SLVERR}, {6'h00, resp_q});
        wr(12'h020, 8'hff);
        chk("bad bresp", {6'h00, `DPPIO_RESP_SLVERR}, {6'h00, bresp_q});
        rchk("d after", 12'h00c, 8'h3a);
        s_axi_wstrb <= 4'he;
        wr(12'h00c, 8'h00);
        @(posedge aclk);
        s_axi_wstrb <= 4'hf;
        chk("strb bresp", {6'h00, `DPPIO_RESP_OKAY}, {6'h00, bresp_q});
        rchk("d strb", 12'h00c, 8'h3a);
    endtask

    task automatic t_keep();
        do_reset();
        t_reset_state();
        wr(12'h014, 8'hff);
        wr(12'h010, 8'hff);
        rchk("d keep", 12'h00c, 8'h5a);
        rchk("b keep", 12'h004, 8'h3c);
    endtask

    initial begin
        do_reset();
        t_reset_state();
        t_portd();
        t_portb();
        t_unmapped();
        t_keep();
        complete_run();
    end

    // the sequence needs well under a thousand cycles
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            complete_run();
        end
    end
endmodule

bind dppio_top dppio_monitor mon_u (.aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_bvalid, .portb_pin_in,
    .portb_pins, .portd_pin_in, .portd_pins, .analog_channel_select);
